// >>> verilog/prs_defines.svh
`ifndef PRS_DEFINES_SVH
`define PRS_DEFINES_SVH

`define PRS_ADDR_TUG3_POS 8'hC0
`define PRS_ADDR_PLL_CFG 8'hC7
`define PRS_TUG3_POS_RST 8'h00
`define PRS_PLL_CFG_RST 8'h00
`define PRS_PLL_GAIN_BIT 4
`define PRS_PLL_INV_BIT 3
`define PRS_DROP_LSB 0
`define PRS_ADD_LSB 4
`define PRS_SLOT_W 4
`define PRS_CLK_PERIOD_NS 5
`define PRS_STABLE_MIN_NS 200
`define PRS_STABLE_CYC ((`PRS_STABLE_MIN_NS + `PRS_CLK_PERIOD_NS - 1) / `PRS_CLK_PERIOD_NS)
`define PRS_CNT_W 8

`endif

// >>> verilog/prs_pkg.sv
package prs_pkg;
    typedef enum logic [1:0] {
        PRS_RESET   = 2'b00,
        PRS_PROGRAM = 2'b01,
        PRS_LOCKING = 2'b10,
        PRS_RUN     = 2'b11
    } prs_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } prs_bus_t;

    typedef struct packed {
        logic [3:0] add_slot_select;
        logic [3:0] drop_slot_select;
    } prs_slots_t;
endpackage

// >>> verilog/prs_sequencer.sv
// Functional notes
// - Internal reset takes effect only after the reset pin has been low with clocks stable for 200 ns.
// - While tri-state control is low the tri-statable outputs are released; it stays low until the position register is written.
// - Once tri-state control goes high the block locks to the C1 pulse and uses the drop and add slot selects.
// - Phase detector gain follows bit 4 of the PLL config register, which software writes as 1.
// - The VCXO control output is inverted when bit 3 of the PLL config register is 1.
`include "prs_defines.svh"

module prs_sequencer
    import prs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reset_n,
    input wire logic i_tri_n,
    input wire logic i_clocks_stable,
    input wire logic i_c1_pulse,
    input wire prs_bus_t i_bus,
    input wire logic i_vcxo_ctrl,
    output logic [7:0] o_rdata,
    output logic o_core_reset,
    output logic o_out_enable,
    output logic o_locked,
    output prs_slots_t o_slots,
    output logic o_phase_detector_gain_select,
    output logic o_vcxo_drive_polarity,
    output logic o_vcxo_ctrl,
    output logic [1:0] o_state
);

    logic rst_n_s1, rst_n_s2, tri_s1, tri_s2, stab_s1, stab_s2, c1_s1, c1_s2;
    logic [`PRS_CNT_W-1:0] cnt, next_cnt;
    logic core_reset, next_core_reset;
    logic [7:0] tug3_pos, next_tug3_pos, pll_cfg, next_pll_cfg;
    prs_state_t state, next_state;
    logic [7:0] next_rdata;

    // pins are asynchronous to i_clk
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rst_n_s1 <= 1'b0;
            rst_n_s2 <= 1'b0;
            tri_s1 <= 1'b0;
            tri_s2 <= 1'b0;
            stab_s1 <= 1'b0;
            stab_s2 <= 1'b0;
            c1_s1 <= 1'b0;
            c1_s2 <= 1'b0;
        end
        else
        begin
            rst_n_s1 <= i_reset_n;
            rst_n_s2 <= rst_n_s1;
            tri_s1 <= i_tri_n;
            tri_s2 <= tri_s1;
            stab_s1 <= i_clocks_stable;
            stab_s2 <= stab_s1;
            c1_s1 <= i_c1_pulse;
            c1_s2 <= c1_s1;
        end
    end

    // a reset pulse shorter than the stable window, or one given while clocks wander, is ignored
    always_comb
    begin
        next_cnt = cnt;
        next_core_reset = core_reset;
        if (!rst_n_s2 && stab_s2)
        begin
            if (cnt < `PRS_CNT_W'(`PRS_STABLE_CYC))
                next_cnt = cnt + `PRS_CNT_W'(1);
            else
                next_core_reset = 1'b1;
        end
        else
        begin
            next_cnt = '0;
            if (rst_n_s2)
                next_core_reset = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt <= '0;
            core_reset <= 1'b1;
        end
        else
        begin
            cnt <= next_cnt;
            core_reset <= next_core_reset;
        end
    end

    always_comb
    begin
        next_tug3_pos = tug3_pos;
        next_pll_cfg = pll_cfg;
        next_rdata = 8'h00;
        if (core_reset)
        begin
            next_tug3_pos = `PRS_TUG3_POS_RST;
            next_pll_cfg = `PRS_PLL_CFG_RST;
        end
        else if (i_bus.wr)
        begin
            if (i_bus.addr == `PRS_ADDR_TUG3_POS)
            begin
                next_tug3_pos = i_bus.wdata;
            end
            else if (i_bus.addr == `PRS_ADDR_PLL_CFG)
                next_pll_cfg = i_bus.wdata;
        end
        if (i_bus.rd)
        begin
            if (i_bus.addr == `PRS_ADDR_TUG3_POS)
                next_rdata = tug3_pos;
            else if (i_bus.addr == `PRS_ADDR_PLL_CFG)
                next_rdata = pll_cfg;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tug3_pos <= `PRS_TUG3_POS_RST;
            pll_cfg <= `PRS_PLL_CFG_RST;
            o_rdata <= 8'h00;
        end
        else
        begin
            tug3_pos <= next_tug3_pos;
            pll_cfg <= next_pll_cfg;
            o_rdata <= next_rdata;
        end
    end

    // sequence: reset -> wait for tri release -> wait for C1 -> run
    always_comb
    begin
        next_state = state;
        case (state)
            PRS_RESET:
                if (!core_reset)
                    next_state = PRS_PROGRAM;
            PRS_PROGRAM:
                if (tri_s2)
                    next_state = PRS_LOCKING;
            PRS_LOCKING:
                if (!tri_s2)
                    next_state = PRS_PROGRAM;
                else if (c1_s2)
                    next_state = PRS_RUN;
            PRS_RUN:
                if (!tri_s2)
                    next_state = PRS_PROGRAM;
            default:
                next_state = PRS_RESET;
        endcase
        if (core_reset)
            next_state = PRS_RESET;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= PRS_RESET;
            o_core_reset <= 1'b1;
            o_out_enable <= 1'b0;
            o_locked <= 1'b0;
            o_slots <= '0;
            o_phase_detector_gain_select <= 1'b0;
            o_vcxo_drive_polarity <= 1'b0;
            o_vcxo_ctrl <= 1'b0;
            o_state <= 2'b00;
        end
        else
        begin
            state <= next_state;
            o_core_reset <= core_reset;
            // outputs stay high impedance until tri control is high
            o_out_enable <= tri_s2 && !core_reset;
            o_locked <= (next_state == PRS_RUN);
            o_slots.drop_slot_select <= tug3_pos[`PRS_DROP_LSB +: `PRS_SLOT_W];
            o_slots.add_slot_select <= tug3_pos[`PRS_ADD_LSB +: `PRS_SLOT_W];
            o_phase_detector_gain_select <= pll_cfg[`PRS_PLL_GAIN_BIT];
            o_vcxo_drive_polarity <= pll_cfg[`PRS_PLL_INV_BIT];
            o_vcxo_ctrl <= i_vcxo_ctrl ^ pll_cfg[`PRS_PLL_INV_BIT];
            o_state <= next_state;
        end
    end

    property p_reset_needs_window;
        @(posedge i_clk) disable iff (i_rst)
        $rose(core_reset) |-> $past(stab_s2) && !$past(rst_n_s2);
    endproperty
    a_reset_needs_window: assert property (p_reset_needs_window)
        else $error("core reset asserted without a stable low window");

    property p_hiz_while_tri_low;
        @(posedge i_clk) disable iff (i_rst)
        !tri_s2 |=> !o_out_enable;
    endproperty
    a_hiz_while_tri_low: assert property (p_hiz_while_tri_low)
        else $error("outputs enabled while tri control low");

    property p_lock_on_c1;
        @(posedge i_clk) disable iff (i_rst)
        (state == PRS_LOCKING && tri_s2 && c1_s2 && !core_reset) |=> o_locked;
    endproperty
    a_lock_on_c1: assert property (p_lock_on_c1)
        else $error("no lock after C1 pulse");

    property p_gain_follows;
        @(posedge i_clk) disable iff (i_rst)
        ##1 o_phase_detector_gain_select == $past(pll_cfg[`PRS_PLL_GAIN_BIT]);
    endproperty
    a_gain_follows: assert property (p_gain_follows)
        else $error("gain select does not follow config bit");

    property p_vcxo_invert;
        @(posedge i_clk) disable iff (i_rst)
        ##1 o_vcxo_ctrl == ($past(i_vcxo_ctrl) ^ $past(pll_cfg[`PRS_PLL_INV_BIT]));
    endproperty
    a_vcxo_invert: assert property (p_vcxo_invert)
        else $error("vcxo control polarity wrong");

endmodule

// >>> tb/prs_ctrl_model.sv
module prs_ctrl_model
    import prs_pkg::*;
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic o_reset_n,
    output logic o_tri_n,
    output logic o_clocks_stable,
    output logic o_c1_pulse,
    output prs_bus_t o_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_reset_n = 1'b0;
        o_tri_n = 1'b0;
        o_clocks_stable = 1'b1;
        o_c1_pulse = 1'b0;
        o_bus = '0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // pins move together on one edge
    task automatic pins(input logic rn, input logic tn, input logic cs, input logic c1);
        @(posedge i_clk);
        o_reset_n <= rn;
        o_tri_n <= tn;
        o_clocks_stable <= cs;
        o_c1_pulse <= c1;
    endtask
    // released address and data are inverted so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk) o_bus <= '{1'b1, 1'b0, a, d};
        @(posedge i_clk) o_bus <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    // read strobe is held for two edges and only the first registered answer is kept
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk) o_bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_clk);
        // taken at the edge, before the design updates its read register
        @(posedge i_clk) o_bus <= '{1'b0, 1'b0, ~a, 8'hFF};
        d = i_rdata;
    endtask
endmodule

// >>> tb/prs_sequencer_test.sv
module prs_sequencer_test;
    import prs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, vc, rn, tn, cs, c1, cr, oe, lk, gn, pl, vo;
    logic [7:0] rdata, d, pos, cfg;
    logic [1:0] st;
    prs_bus_t bus;
    prs_slots_t sl;
    int mismatches = 0;
    int checks_done = 0;
    integer seed = 32'hECAE;
    prs_ctrl_model i_prs_ctrl_model (.i_clk(clk), .i_rdata(rdata), .o_reset_n(rn), .o_tri_n(tn),
        .o_clocks_stable(cs), .o_c1_pulse(c1), .o_bus(bus));
    prs_sequencer i_prs_sequencer (.i_clk(clk), .i_rst(rst), .i_reset_n(rn), .i_tri_n(tn),
        .i_clocks_stable(cs), .i_c1_pulse(c1), .i_bus(bus), .i_vcxo_ctrl(vc), .o_rdata(rdata),
        .o_core_reset(cr), .o_out_enable(oe), .o_locked(lk), .o_slots(sl),
        .o_phase_detector_gain_select(gn), .o_vcxo_drive_polarity(pl), .o_vcxo_ctrl(vo),
        .o_state(st));
    function automatic logic exp_vcxo(input logic v, input logic [7:0] c);
        return v ^ c[3];
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        #20000;
        mismatches++;
        results();
    end
    initial
    begin
        rst = 1'b1;
        vc = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        i_prs_ctrl_model.wr(8'hC0, 8'hA5);
        i_prs_ctrl_model.rd(8'hC0, d);
        chk("pos_in_reset", d, 8'h00);
        i_prs_ctrl_model.cyc(45);
        // stray frame pulses while tri control is low must not lock
        i_prs_ctrl_model.pins(1, 0, 1, 1'($random(seed)));
        i_prs_ctrl_model.cyc(8);
        chk("core_reset", cr, 0);
        chk("state", st, 1);
        chk("out_enable", oe, 0);
        for (int i = 0; i < 6; i++)
        begin
            pos = 8'($random(seed));
            // software always writes the gain bit as one
            cfg = (i == 0) ? 8'h18 : (i == 1) ? 8'h10 : (8'($random(seed)) | 8'h10);
            @(posedge clk) vc <= 1'($random(seed));
            i_prs_ctrl_model.wr(8'hC0, pos);
            i_prs_ctrl_model.wr(8'hC7, cfg);
            i_prs_ctrl_model.rd(8'hC0, d);
            chk("pos", d, pos);
            i_prs_ctrl_model.rd(8'hC7, d);
            chk("pll_cfg", d, cfg);
            chk("slots", sl, pos);
            chk("gain", gn, cfg[4]);
            chk("polarity", pl, cfg[3]);
            chk("vcxo", vo, exp_vcxo(vc, cfg));
        end
        i_prs_ctrl_model.wr(8'hC3, 8'hFF);
        i_prs_ctrl_model.rd(8'hC3, d);
        chk("unmapped", d, 8'h00);
        // position is programmed by now, so tri control may rise
        i_prs_ctrl_model.pins(1, 1, 1, 0);
        i_prs_ctrl_model.cyc(6);
        chk("out_enable", oe, 1);
        chk("state", {lk, st}, 3'b010);
        chk("rdata_idle", rdata, 8'h00);
        i_prs_ctrl_model.pins(1, 1, 1, 1);
        i_prs_ctrl_model.pins(1, 1, 1, 0);
        i_prs_ctrl_model.cyc(5);
        chk("locked", {lk, st}, 3'b111);
        i_prs_ctrl_model.pins(1, 0, 1, 1'($random(seed)));
        i_prs_ctrl_model.cyc(6);
        chk("tri_low", {oe, lk, st}, 4'b0001);
        i_prs_ctrl_model.pins(0, 0, 1, 1'($random(seed)));
        i_prs_ctrl_model.cyc(20);
        i_prs_ctrl_model.pins(0, 0, 0, 1'($random(seed)));
        i_prs_ctrl_model.pins(0, 0, 1, 0);
        i_prs_ctrl_model.cyc(35);
        chk("early_reset", cr, 0);
        i_prs_ctrl_model.cyc(15);
        chk("pin_reset", cr, 1);
        i_prs_ctrl_model.pins(1, 0, 1, 1'($random(seed)));
        i_prs_ctrl_model.cyc(8);
        i_prs_ctrl_model.rd(8'hC0, d);
        chk("pos_cleared", d, 8'h00);
        results();
    end
endmodule
